// ### src/dmac_pkg.sv
// package for the multiply-to-accumulator datapath: register map,
// field positions, reset values, state and carrier types.
// assumes a 32-bit apb slave and 16-bit x/y data memory read ports.
package dmac_pkg;
  // apb byte offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h04;
  localparam logic [7:0] OFS_WREG0 = 8'h08;
  localparam logic [7:0] OFS_WREG_LAST = 8'h28;
  localparam logic [7:0] OFS_ACCUMULATOR_A_LO = 8'h2C;
  localparam logic [7:0] OFS_ACCUMULATOR_A_HI = 8'h30;
  localparam logic [7:0] OFS_ACCUMULATOR_B_LO = 8'h34;
  localparam logic [7:0] OFS_ACCUMULATOR_B_HI = 8'h38;
  localparam logic [7:0] OFS_FLAGS = 8'h3C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
  // working register indices (w4..w12 held as 0..8)
  localparam logic [3:0] WIDX_XPTR = 4'h4;
  localparam logic [3:0] WIDX_YPTR = 4'h6;
  localparam logic [3:0] WIDX_OFFSET = 4'h8;
  // opcode fields
  localparam logic [3:0] MAC_NIBBLE = 4'hC;
  localparam logic [3:0] SQR_NIBBLE = 4'hF;
  localparam logic [1:0] MPY_TAIL = 2'h3;
  localparam logic [1:0] SQR_TAIL = 2'h1;
  localparam int ACC_SEL_BIT = 15;
  localparam int NEG_BIT = 14;
  localparam logic [3:0] PF_NONE = 4'h4;
  localparam logic [3:0] PF_OFFSET = 4'hC;
  // core control fields
  localparam int CC_INT_BIT = 0;
  localparam int CC_US_LO = 12;
  localparam int CC_US_HI = 13;
  localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
  // flag bits
  localparam int FL_OA = 0;
  localparam int FL_OB = 1;
  localparam int FL_OAB = 2;
  localparam int FL_SA = 3;
  localparam int FL_SB = 4;
  localparam int FL_SAB = 5;
  // event bits
  localparam int EV_DONE = 0;
  localparam int EV_OVF = 1;
  localparam int EV_ILLEGAL = 2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_FETCH = 5'h02,
    ST_READ = 5'h04,
    ST_HOLD = 5'h08,
    ST_DONE = 5'h10
  } dmac_state_t;

  typedef struct packed {
    logic en;
    logic [15:0] addr;
  } dmac_mem_req_t;

  typedef struct packed {
    logic en;
    logic ofs;
    logic [1:0] dst;
    logic [3:0] ptr;
    logic [15:0] addr;
    logic [15:0] step;
  } dmac_pf_t;
endpackage

// ### src/dmac_core.sv
// multiply-to-accumulator datapath with x/y operand prefetch, apb slave.
// assumes x/y memories return data in the cycle after a read enable.
//
// Contract
// - plain multiply loads sign-extended 40-bit product into accumulator
// - square multiplies one of w4..w7 by itself, own opcode pattern
// - negated multiply loads minus the product, with its opcode pattern
// - negated multiply accepts only the six ordered operand pairs
// - plain multiply and square update overflow and saturation flags; negated only overflow
// - one opcode bit selects accumulator a or b
// - x prefetch reads via w8/w9 then adds even step -6..6
// - y prefetch reads via w10/w11 then adds even step -6..6
// - offset mode adds w12 to pointer and leaves pointer alone
// - decode x/y destination and x/y prefetch operation fields
// - multiply field decodes to a permitted pair feeding multiplier
// - core control bit 0 selects integer or fractional multiply
// - signedness field picks unsigned, signed or mixed-sign
`timescale 1ns/100ps
module dmac_core #(
  parameter int AW = 8,
  parameter bit NEW_US = 1'b1
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output dmac_pkg::dmac_mem_req_t x_req, // x memory read request
  output dmac_pkg::dmac_mem_req_t y_req, // y memory read request
  input wire logic [15:0] x_rd_data, // x memory read data
  input wire logic [15:0] y_rd_data, // y memory read data
  output logic irq // level interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  dmac_pkg::dmac_state_t state, next_state;
  logic [23:0] instr, next_instr;
  logic [15:0] cc, next_cc;
  logic [15:0] w [0:8];
  logic [15:0] next_w [0:8];
  logic [39:0] acc_a, acc_b, next_acc_a, next_acc_b;
  logic [5:0] flags, next_flags;
  logic [2:0] ev, next_ev, ev_mask, next_ev_mask, ev_set, ev_clr;
  logic [15:0] xdat, ydat, next_xdat, next_ydat;
  logic [31:0] next_prdata, rd_val;
  logic next_pready, next_pslverr, next_irq, rd_hit;
  dmac_pkg::dmac_mem_req_t next_x_req, next_y_req;
  dmac_pkg::dmac_pf_t x_pf, y_pf;
  logic is_mpy, is_sqr, is_neg, pair_ok, legal, acc_sel, commit;
  logic [1:0] ia, ib, us;
  logic sgn_a, sgn_b, sat_hit, ovf_hit;
  logic signed [33:0] prod;
  logic [39:0] ext40, mag, res;
  logic [40:0] res41;
  logic [3:0] widx;

  // one prefetch field: pointer pick, step and addressing mode
  function automatic dmac_pkg::dmac_pf_t pf_decode(
    input logic [3:0] code,
    input logic [1:0] dst,
    input logic [3:0] base,
    input logic [15:0] p0,
    input logic [15:0] p1,
    input logic [15:0] ofs
  );
    dmac_pkg::dmac_pf_t r;
    logic [15:0] p;
    r.en = code != dmac_pkg::PF_NONE;
    r.ofs = code == dmac_pkg::PF_OFFSET;
    r.dst = dst;
    r.ptr = base + {3'h0, code[3]};
    p = code[3] ? p1 : p0;
    r.addr = r.ofs ? p + ofs : p;
    // low three bits are a signed step in words; 000 and 100 mean none
    if (code[1:0] == 2'h0) begin
      r.step = 16'h0000;
    end else begin
      r.step = {{12{code[2]}}, code[2:0], 1'b0};
    end
    return r;
  endfunction

  // opcode decode of the latched instruction word
  always_comb begin
    is_mpy = instr[23:20] == dmac_pkg::MAC_NIBBLE && !instr[19] &&
             !instr[dmac_pkg::NEG_BIT] && instr[1:0] == dmac_pkg::MPY_TAIL;
    is_neg = instr[23:20] == dmac_pkg::MAC_NIBBLE && !instr[19] &&
             instr[dmac_pkg::NEG_BIT] &&
             instr[1:0] == dmac_pkg::MPY_TAIL;
    is_sqr = instr[23:20] == dmac_pkg::SQR_NIBBLE &&
             instr[19:18] == 2'h0 && !instr[dmac_pkg::NEG_BIT] &&
             instr[1:0] == dmac_pkg::SQR_TAIL;
    acc_sel = instr[dmac_pkg::ACC_SEL_BIT];
    pair_ok = 1'b1;
    ia = 2'h0;
    ib = 2'h1;
    case (instr[18:16])
      3'h0: begin ia = 2'h0; ib = 2'h1; end
      3'h1: begin ia = 2'h0; ib = 2'h2; end
      3'h2: begin ia = 2'h0; ib = 2'h3; end
      3'h4: begin ia = 2'h1; ib = 2'h2; end
      3'h5: begin ia = 2'h1; ib = 2'h3; end
      3'h6: begin ia = 2'h2; ib = 2'h3; end
      default: pair_ok = 1'b0;
    endcase
    if (is_sqr) begin
      ia = instr[17:16];
      ib = instr[17:16];
    end
    legal = is_sqr || ((is_mpy || is_neg) && pair_ok);
    x_pf = pf_decode(instr[9:6], instr[13:12], dmac_pkg::WIDX_XPTR,
                     w[4], w[5], w[8]);
    y_pf = pf_decode(instr[5:2], instr[11:10], dmac_pkg::WIDX_YPTR,
                     w[6], w[7], w[8]);
  end

  // multiplier: signedness, integer or fractional, negation, flags
  always_comb begin
    us = NEW_US ? cc[dmac_pkg::CC_US_HI:dmac_pkg::CC_US_LO]
                : {1'b0, cc[dmac_pkg::CC_US_LO]};
    sgn_a = us == 2'h0 || us == 2'h3; // mixed: first unsigned
    sgn_b = us != 2'h1;
    prod = $signed({sgn_a & w[ia][15], w[ia]}) *
           $signed({sgn_b & w[ib][15], w[ib]});
    ext40 = {{6{prod[33]}}, prod};
    mag = cc[dmac_pkg::CC_INT_BIT] ? ext40 : {ext40[38:0], 1'b0};
    res41 = is_neg ? 41'(-$signed({mag[39], mag})) : {mag[39], mag};
    res = res41[39:0];
    sat_hit = res41[40] ^ res41[39];
    ovf_hit = !(&res[39:31] || ~|res[39:31]);
  end

  // register read mux; if chain keeps decode priority obvious
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    widx = 4'((paddr[7:0] - dmac_pkg::OFS_WREG0) >> 2);
    if (paddr[7:0] == dmac_pkg::OFS_INSTR) begin
      rd_val = {8'h00, instr};
    end else if (paddr[7:0] == dmac_pkg::OFS_CORE_CTRL) begin
      rd_val = {16'h0000, cc};
    end else if (paddr[7:0] >= dmac_pkg::OFS_WREG0 &&
                 paddr[7:0] <= dmac_pkg::OFS_WREG_LAST &&
                 paddr[1:0] == 2'h0) begin
      rd_val = {16'h0000, w[widx]};
    end else if (paddr[7:0] == dmac_pkg::OFS_ACCUMULATOR_A_LO) begin
      rd_val = acc_a[31:0];
    end else if (paddr[7:0] == dmac_pkg::OFS_ACCUMULATOR_A_HI) begin
      rd_val = {24'h000000, acc_a[39:32]};
    end else if (paddr[7:0] == dmac_pkg::OFS_ACCUMULATOR_B_LO) begin
      rd_val = acc_b[31:0];
    end else if (paddr[7:0] == dmac_pkg::OFS_ACCUMULATOR_B_HI) begin
      rd_val = {24'h000000, acc_b[39:32]};
    end else if (paddr[7:0] == dmac_pkg::OFS_FLAGS) begin
      rd_val = {26'h0000000, flags};
    end else if (paddr[7:0] == dmac_pkg::OFS_IRQ_STAT) begin
      rd_val = {29'h00000000, ev};
    end else if (paddr[7:0] == dmac_pkg::OFS_IRQ_MASK) begin
      rd_val = {29'h00000000, ev_mask};
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign commit = state == dmac_pkg::ST_DONE && psel && penable;

  // next state of sequencer, bus answer and architectural registers
  always_comb begin
    next_state = state;
    next_instr = instr;
    next_cc = cc;
    next_w = w;
    next_acc_a = acc_a;
    next_acc_b = acc_b;
    next_flags = flags;
    next_ev_mask = ev_mask;
    next_xdat = xdat;
    next_ydat = ydat;
    next_prdata = prdata;
    next_pready = pready;
    next_pslverr = pslverr;
    next_x_req = x_req;
    next_y_req = y_req;
    ev_set = 3'h0;
    ev_clr = 3'h0;
    case (state)
      dmac_pkg::ST_IDLE: begin
        if (psel && !penable) begin
          if (pwrite && paddr[7:0] == dmac_pkg::OFS_INSTR) begin
            next_instr = pwdata[23:0];
            next_state = dmac_pkg::ST_FETCH;
          end else begin
            next_pready = 1'b1;
            next_prdata = pwrite ? 32'h0000_0000 : rd_val;
            next_pslverr = !rd_hit;
          end
        end else if (psel && penable && pready) begin
          next_pready = 1'b0;
          next_pslverr = 1'b0;
          if (pwrite && rd_hit) begin
            if (paddr[7:0] == dmac_pkg::OFS_CORE_CTRL) begin
              next_cc = pwdata[15:0];
            end else if (paddr[7:0] >= dmac_pkg::OFS_WREG0 &&
                         paddr[7:0] <= dmac_pkg::OFS_WREG_LAST) begin
              next_w[widx] = pwdata[15:0];
            end else if (paddr[7:0] == dmac_pkg::OFS_IRQ_STAT) begin
              ev_clr = pwdata[2:0];
            end else if (paddr[7:0] == dmac_pkg::OFS_IRQ_MASK) begin
              next_ev_mask = pwdata[2:0];
            end
          end
        end
      end
      dmac_pkg::ST_FETCH: begin
        // illegal words never touch memory
        next_x_req = '{en: legal && x_pf.en, addr: x_pf.addr};
        next_y_req = '{en: legal && y_pf.en, addr: y_pf.addr};
        next_state = dmac_pkg::ST_READ;
      end
      dmac_pkg::ST_READ: begin
        next_x_req.en = 1'b0;
        next_y_req.en = 1'b0;
        next_state = dmac_pkg::ST_HOLD;
      end
      dmac_pkg::ST_HOLD: begin
        next_xdat = x_rd_data;
        next_ydat = y_rd_data;
        next_pready = 1'b1;
        next_state = dmac_pkg::ST_DONE;
      end
      dmac_pkg::ST_DONE: begin
        if (commit) begin
          next_pready = 1'b0;
          next_state = dmac_pkg::ST_IDLE;
          if (legal) begin
            // operands were read from w before this edge, so fetched
            // words only reach the next instruction
            if (x_pf.en) begin
              next_w[x_pf.dst] = xdat;
            end
            if (y_pf.en) begin
              next_w[y_pf.dst] = ydat; // y wins a shared destination
            end
            if (x_pf.en && !x_pf.ofs) begin
              next_w[x_pf.ptr] = w[x_pf.ptr] + x_pf.step;
            end
            if (y_pf.en && !y_pf.ofs) begin
              next_w[y_pf.ptr] = w[y_pf.ptr] + y_pf.step;
            end
            if (acc_sel) begin
              next_acc_b = res;
              next_flags[dmac_pkg::FL_OB] = ovf_hit;
              if (!is_neg) begin
                next_flags[dmac_pkg::FL_SB] = sat_hit;
              end
            end else begin
              next_acc_a = res;
              next_flags[dmac_pkg::FL_OA] = ovf_hit;
              if (!is_neg) begin
                next_flags[dmac_pkg::FL_SA] = sat_hit;
              end
            end
            ev_set[dmac_pkg::EV_DONE] = 1'b1;
            ev_set[dmac_pkg::EV_OVF] = ovf_hit;
          end else begin
            ev_set[dmac_pkg::EV_ILLEGAL] = 1'b1;
          end
        end
      end
      default: next_state = dmac_pkg::ST_IDLE;
    endcase
    next_flags[dmac_pkg::FL_OAB] = next_flags[dmac_pkg::FL_OA] |
                                   next_flags[dmac_pkg::FL_OB];
    next_flags[dmac_pkg::FL_SAB] = next_flags[dmac_pkg::FL_SA] |
                                   next_flags[dmac_pkg::FL_SB];
    next_ev = (ev & ~ev_clr) | ev_set; // set beats clear
    next_irq = |(next_ev & next_ev_mask);
  end

  // registers only; every output leaves from here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dmac_pkg::ST_IDLE;
      instr <= 24'h000000;
      cc <= dmac_pkg::CORE_CTRL_RST;
      for (int i = 0; i < 9; i++) begin
        w[i] <= 16'h0000;
      end
      acc_a <= 40'h00_0000_0000;
      acc_b <= 40'h00_0000_0000;
      flags <= 6'h00;
      ev <= 3'h0;
      ev_mask <= 3'h0;
      xdat <= 16'h0000;
      ydat <= 16'h0000;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      x_req <= '0;
      y_req <= '0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      instr <= next_instr;
      cc <= next_cc;
      w <= next_w;
      acc_a <= next_acc_a;
      acc_b <= next_acc_b;
      flags <= next_flags;
      ev <= next_ev;
      ev_mask <= next_ev_mask;
      xdat <= next_xdat;
      ydat <= next_ydat;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      x_req <= next_x_req;
      y_req <= next_y_req;
      irq <= next_irq;
    end
  end

  chk_acc_load: assert property (commit && legal && !acc_sel |=>
    acc_a == $past(res)) else $error("accumulator a not loaded");
  chk_acc_other: assert property (commit && acc_sel |=>
    acc_a == $past(acc_a)) else $error("unselected accumulator moved");
  // a signed square can never come out negative
  chk_square_op: assert property (commit && is_sqr && !acc_sel &&
    cc[13:12] == 2'h0 |=> !acc_a[39]) else $error("square negative");
  chk_neg_result: assert property (commit && legal && is_neg && acc_sel
    |=> acc_b == 40'(-$past(mag))) else $error("negation wrong");
  chk_neg_pairs: assert property (commit && is_neg && legal |->
    ia < ib) else $error("bad operand pair accepted");
  chk_flag_merge: assert property (flags[dmac_pkg::FL_OAB] ==
    (flags[dmac_pkg::FL_OA] | flags[dmac_pkg::FL_OB]))
    else $error("combined overflow flag wrong");
  chk_neg_satkeep: assert property (commit && is_neg |=>
    $stable(flags[5:3])) else $error("saturation flags changed");
  chk_xptr_step: assert property (commit && legal && x_pf.en &&
    !x_pf.ofs |=> w[$past(x_pf.ptr)] == $past(w[x_pf.ptr]) +
    $past(x_pf.step)) else $error("x pointer step wrong");
  chk_ofs_hold: assert property (commit && legal && y_pf.ofs |=>
    w[7] == $past(w[7])) else $error("offset pointer modified");
  chk_req_issue: assert property (state == dmac_pkg::ST_FETCH && legal
    && y_pf.en |=> y_req.en ##1 !y_req.en)
    else $error("y read not issued once");
  chk_one_commit: assert property (state == dmac_pkg::ST_FETCH |=>
    ##2 pready && state == dmac_pkg::ST_DONE) else $error("late commit");
  chk_int_mode: assert property (commit && legal && cc[0] && !is_neg &&
    !acc_sel |=> acc_a[0] == $past(prod[0])) else $error("int mode off");
  chk_irq_level: assert property (irq == |(ev & ev_mask))
    else $error("interrupt level wrong");

  cov_square: cover property (commit && is_sqr);
  cov_negated: cover property (commit && is_neg && acc_sel);
  cov_offset: cover property (commit && x_pf.ofs && y_pf.en);
  cov_illegal: cover property (commit && !legal);
endmodule

// ### sim/dmac_mem_model.sv
// x and y data memory read ports with one cycle of read latency.
// assumes one-cycle read enables from the datapath, address held after.
`timescale 1ns/100ps
module dmac_mem_model (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, low
  input wire dmac_pkg::dmac_mem_req_t x_req, // x read request
  input wire dmac_pkg::dmac_mem_req_t y_req, // y read request
  output logic [15:0] x_rd_data, // x read data
  output logic [15:0] y_rd_data // y read data
);
  // data stands one cycle only; then it flips to its inverse every cycle, so a
  // sample one cycle late in the datapath cannot match by luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_rd_data <= 16'h0000;
      y_rd_data <= 16'h0000;
    end else begin
      x_rd_data <= x_req.en ?
        {x_req.addr[7:0], x_req.addr[15:8]} ^ 16'h1234 : ~x_rd_data;
      y_rd_data <= y_req.en ?
        {y_req.addr[7:0], y_req.addr[15:8]} ^ 16'h4321 : ~y_rd_data;
    end
  end
endmodule

// ### sim/tb_top.sv
// self-checking bench for the multiply-to-accumulator datapath.
// assumes the apb slave and the memory model of dmac_mem_model.
`timescale 1ns/100ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [15:0] x_rd_data;
  logic [15:0] y_rd_data;
  dmac_pkg::dmac_mem_req_t x_req;
  dmac_pkg::dmac_mem_req_t y_req;
  logic [31:0] rdat;
  logic serr;
  logic [15:0] w [0:8];
  logic [39:0] acc [0:1];
  logic [1:0] ov = 2'h0;
  logic [15:0] cc = 16'h0000;
  logic [2:0] xc;
  int j;
  int mismatches = 0;
  int n_checks = 0;
  localparam logic [15:0] PA = 16'h2500;
  localparam logic [15:0] PB = 16'h3E39;
  localparam logic [143:0] INIT =
    144'h3023_1290_C000_9000_1000_2000_0002_4000_0040;

  dmac_core #(.AW(8), .NEW_US(1'b1)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .x_req(x_req), .y_req(y_req),
    .x_rd_data(x_rd_data), .y_rd_data(y_rd_data), .irq(irq)
  );
  dmac_mem_model mem (
    .pclk(pclk), .presetn(presetn), .x_req(x_req), .y_req(y_req),
    .x_rd_data(x_rd_data), .y_rd_data(y_rd_data)
  );

  always #10 pclk = ~pclk;

  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one transfer; entered just after an edge, leaves one idle edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) mismatches++;
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [15:0] mword(input logic y, logic [15:0] a);
    return {a[7:0], a[15:8]} ^ (y ? 16'h4321 : 16'h1234);
  endfunction

  // first operand unsigned for codes 01 and 10, second only for 01
  function automatic logic [39:0] prod(input logic [15:0] p, q);
    logic [40:0] sa, sb;
    sa = {{25{p[15] & ~(cc[13] ^ cc[12])}}, p};
    sb = {{25{q[15] & ~(~cc[13] & cc[12])}}, q};
    sa = sa * sb;
    if (!cc[0]) sa = sa << 1;
    return sa[39:0];
  endfunction

  // prefetch effect on the model; pointer index 4..7 is w8..w11
  task automatic pf(input logic y, input logic [3:0] c, input logic [1:0] d);
    logic [3:0] p;
    logic [15:0] ad;
    p = {2'h1, y, c[3]};
    ad = (c == 4'hC) ? w[p] + w[8] : w[p];
    // codes x000 and x100 leave the pointer where it is
    if (c[1:0] != 2'h0) w[p] = w[p] + {{12{c[2]}}, c[2:0], 1'b0};
    if (c != 4'h4) w[{2'h0, d}] = mword(y, ad);
  endtask

  task automatic load_w();
    for (int k = 0; k < 9; k++)
      wr(dmac_pkg::OFS_WREG0 + 8'(4 * k), {16'h0000, w[k]});
  endtask

  task automatic check_all();
    for (int k = 0; k < 9; k++) begin
      rd(dmac_pkg::OFS_WREG0 + 8'(4 * k));
      chk("wreg", {16'h0000, w[k]}, rdat);
    end
    for (int k = 0; k < 2; k++) begin
      rd(dmac_pkg::OFS_ACCUMULATOR_A_LO + 8'(8 * k));
      chk("acc_lo", acc[k][31:0], rdat);
      rd(dmac_pkg::OFS_ACCUMULATOR_A_HI + 8'(8 * k));
      chk("acc_hi", {24'h0, acc[k][39:32]}, rdat);
    end
    rd(dmac_pkg::OFS_FLAGS);
    chk("flags", {29'h0, ov[0] | ov[1], ov}, rdat);
  endtask

  // operand product uses values from before this instruction's fetches
  task automatic mac(input logic sq, input logic [2:0] m, input logic a,
    input logic ng, input logic [1:0] xd, yd, input logic [3:0] xi, yi);
    logic [39:0] r;
    logic [23:0] ins;
    if (sq) ins = {4'hF, 2'h0, m[1:0], a, 1'b0, xd, yd, xi, yi, 2'h1};
    else ins = {4'hC, 1'b0, m, a, ng, xd, yd, xi, yi, 2'h3};
    r = sq ? prod(w[m[1:0]], w[m[1:0]]) :
      prod(w[PA[2 * m +: 2]], w[PB[2 * m +: 2]]);
    if (ng && !sq) r = -r;
    acc[a] = r;
    ov[a] = (r[39:31] != 9'h000) && (r[39:31] != 9'h1FF);
    pf(1'b0, xi, xd);
    pf(1'b1, yi, yd);
    wr(dmac_pkg::OFS_INSTR, {8'h00, ins});
    check_all();
  endtask

  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end

  initial begin
    for (int k = 0; k < 9; k++) w[k] = 16'h0000;
    acc[0] = 40'h0;
    acc[1] = 40'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(dmac_pkg::OFS_CORE_CTRL);
    chk("core_ctrl", 32'h0, rdat);
    wr(dmac_pkg::OFS_ACCUMULATOR_A_LO, 32'hFFFFFFFF);
    check_all();
    rd(8'h48);
    chk("unmapped", 32'h1, {31'h0, serr});
    cc = 16'h0001;
    wr(dmac_pkg::OFS_CORE_CTRL, {16'h0000, cc});
    // every pair, both accumulators, plain and negated, all six steps
    for (int i = 0; i < 12; i++) begin
      j = i % 6;
      xc = 3'(j + 1 + (j >= 3));
      for (int k = 0; k < 9; k++) w[k] = INIT[128 - 16 * k +: 16];
      load_w();
      mac(1'b0, 3'(j + (j >= 3)), i[0], i >= 6, i[1:0], ~i[1:0],
        {i[1], xc}, {~i[1], 3'(8 - xc)});
    end
    // squares with offset and no-modify fetches
    for (int i = 0; i < 4; i++)
      mac(1'b1, 3'(i), i[0], 1'b0, 2'(i), 2'(i + 1),
        i < 2 ? 4'hC : {i[0], 3'h0}, i < 2 ? 4'h4 : 4'hC);
    // integer for each signedness code, then fractional signed
    w[0] = 16'h8001;
    w[1] = 16'h0003;
    load_w();
    for (int k = 0; k < 5; k++) begin
      cc = (k == 4) ? 16'h0000 : {2'h0, 2'(k), 11'h0, 1'b1};
      wr(dmac_pkg::OFS_CORE_CTRL, {16'h0000, cc});
      mac(1'b0, 3'h0, k[0], 1'b0, 2'h0, 2'h1, 4'h4, 4'h4);
    end
    // fractional minus one squared overflows, negated form clears it
    w[0] = 16'h8000;
    w[1] = 16'h8000;
    load_w();
    wr(dmac_pkg::OFS_IRQ_STAT, 32'h7);
    mac(1'b0, 3'h0, 1'b0, 1'b0, 2'h0, 2'h1, 4'h4, 4'h4);
    rd(dmac_pkg::OFS_IRQ_STAT);
    chk("irq_stat", 32'h3, rdat);
    mac(1'b0, 3'h0, 1'b0, 1'b1, 2'h0, 2'h1, 4'h4, 4'h4);
    // refused pair: nothing changes, event raised, masked then seen
    wr(dmac_pkg::OFS_IRQ_STAT, 32'h7);
    wr(dmac_pkg::OFS_IRQ_MASK, 32'h0);
    wr(dmac_pkg::OFS_INSTR,
      {8'h00, 4'hC, 1'b0, 3'h3, 2'h0, 2'h0, 2'h1, 4'h1, 4'h1, 2'h3});
    check_all();
    rd(dmac_pkg::OFS_IRQ_STAT);
    chk("illegal", 32'h1, {31'h0, rdat[2]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(dmac_pkg::OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq_set", 32'h1, {31'h0, irq});
    wr(dmac_pkg::OFS_IRQ_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    give_verdict();
  end
endmodule
